//--- edmmt_pkg.sv
// Constants, register layout and state types for the external data move unit.
package edmmt_pkg;

  // ****************************************************************
  // Register offsets and reset values.
  // ****************************************************************
  localparam logic [7:0] ADDR_PAGE = 8'hAA;
  localparam logic [7:0] ADDR_CFG = 8'hAB;
  localparam logic [7:0] ADDR_TIM = 8'hAF;
  localparam logic [4:0] RST_PAGE = 5'h00;
  localparam logic [3:0] RST_CFG = 4'h3;
  localparam logic [7:0] RST_TIM = 8'hFF;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int PAGE_MSB = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int TIM_SETUP_LSB = 6;
  localparam int TIM_STROBE_LSB = 2;
  localparam int TIM_HOLD_LSB = 0;

  // Mapping modes.
  localparam logic [1:0] MODE_INT = 2'h0;
  localparam logic [1:0] MODE_SPLIT = 2'h1;
  localparam logic [1:0] MODE_BANK = 2'h2;
  localparam logic [1:0] MODE_EXT = 2'h3;

  // ****************************************************************
  // Memory geometry and fixed cycle counts.
  // ****************************************************************
  localparam int RAM_BYTES = 4096;
  localparam int IDX_W = 12;
  localparam logic [15:0] RAM_BOUND = 16'h1000;
  localparam logic [3:0] LEAD_LAST = 4'h1;
  localparam logic [3:0] TRAIL_LAST = 4'h1;

  typedef enum logic [3:0] {
    PH_IDLE, PH_LEAD, PH_ALEH, PH_ALEL, PH_SETUP,
    PH_STROBE, PH_HOLD, PH_TRAIL
  } edmmt_phase_t;

  typedef struct packed {
    edmmt_phase_t ph;
    logic [3:0] cnt;
    logic [4:0] page;
    logic [3:0] cfg;
    logic [7:0] tim;
    logic is_wr;
    logic [7:0] lo;
    logic [3:0] hi;
    logic hi_en;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic done;
    logic [7:0] sfr_q;
  } edmmt_regs_t;

endpackage

//--- edmmt_ctrl.sv
// External data move unit: mapping modes, on-chip RAM and off-chip strobes.
module edmmt_ctrl (
  input wire logic core_clk_i, // System clock.
  input wire logic resetn_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable; low freezes all state.
  input wire logic [7:0] sfr_addr_i, // Register address.
  input wire logic sfr_wr_i, // Register write strobe.
  input wire logic sfr_rd_i, // Register read strobe.
  input wire logic [7:0] sfr_wdata_i, // Register write data.
  output logic [7:0] sfr_rdata_o, // Register read data.
  input wire logic mux_mode_i, // High selects multiplexed bus.
  input wire logic req_i, // Move request.
  input wire logic wr_i, // High for a write move.
  input wire logic form16_i, // High for data pointer form.
  input wire logic [15:0] data_pointer_i, // Data pointer value.
  input wire logic [7:0] ptr_i, // Selected pointer register byte.
  input wire logic [7:0] wdata_i, // Move write data.
  output logic [7:0] rdata_o, // Move read data.
  output logic done_o, // One-cycle move completion pulse.
  output logic busy_o, // Off-chip move in progress.
  output logic bus_own_o, // Interface owns its port pins.
  output logic [3:0] addr_hi_o, // Address lines 11:8.
  output logic addr_hi_oe_o, // Drive enable for lines 11:8.
  output logic [7:0] addr_lo_o, // Address lines 7:0, plain bus.
  output logic addr_lo_oe_o, // Drive enable for lines 7:0.
  output logic [7:0] ad_o, // Data or shared address/data out.
  output logic ad_oe_o, // Drive enable for data pins.
  input wire logic [7:0] ad_i, // Data or shared bus in.
  output logic ale_o, // Address latch enable.
  output logic rd_n_o, // Read strobe, active low.
  output logic wr_n_o // Write strobe, active low.
);

  // ****************************************************************
  // State, memory and helpers.
  // ****************************************************************
  edmmt_pkg::edmmt_regs_t r;
  edmmt_pkg::edmmt_regs_t next_r;
  logic [7:0] ram [edmmt_pkg::RAM_BYTES];
  logic ram_we;
  logic [edmmt_pkg::IDX_W-1:0] ram_idx;
  logic [15:0] ea;
  logic [1:0] mode;
  logic go_off;
  logic [1:0] t_setup;
  logic [3:0] t_strobe;
  logic [1:0] t_hold;
  logic [1:0] t_ale;

  // Phase that follows a finished one; zero-length phases are skipped.
  function automatic edmmt_pkg::edmmt_phase_t follow(
    input edmmt_pkg::edmmt_phase_t p,
    input logic mux,
    input logic [1:0] s,
    input logic [1:0] h
  );
    case (p)
      edmmt_pkg::PH_LEAD: begin
        if (mux) follow = edmmt_pkg::PH_ALEH;
        else if (s != 2'h0) follow = edmmt_pkg::PH_SETUP;
        else follow = edmmt_pkg::PH_STROBE;
      end
      edmmt_pkg::PH_ALEH: follow = edmmt_pkg::PH_ALEL;
      edmmt_pkg::PH_ALEL: begin
        if (s != 2'h0) follow = edmmt_pkg::PH_SETUP;
        else follow = edmmt_pkg::PH_STROBE;
      end
      edmmt_pkg::PH_SETUP: follow = edmmt_pkg::PH_STROBE;
      edmmt_pkg::PH_STROBE: begin
        if (h != 2'h0) follow = edmmt_pkg::PH_HOLD;
        else follow = edmmt_pkg::PH_TRAIL;
      end
      edmmt_pkg::PH_HOLD: follow = edmmt_pkg::PH_TRAIL;
      default: follow = edmmt_pkg::PH_IDLE;
    endcase
  endfunction

  // Count to load on entering a phase: its length minus one.
  function automatic logic [3:0] first_cnt(
    input edmmt_pkg::edmmt_phase_t p,
    input logic [1:0] s,
    input logic [3:0] w,
    input logic [1:0] h,
    input logic [1:0] a
  );
    case (p)
      edmmt_pkg::PH_LEAD: first_cnt = edmmt_pkg::LEAD_LAST;
      edmmt_pkg::PH_ALEH: first_cnt = {2'h0, a};
      edmmt_pkg::PH_ALEL: first_cnt = {2'h0, a};
      edmmt_pkg::PH_SETUP: first_cnt = {2'h0, s - 2'h1};
      edmmt_pkg::PH_STROBE: first_cnt = w;
      edmmt_pkg::PH_HOLD: first_cnt = {2'h0, h - 2'h1};
      edmmt_pkg::PH_TRAIL: first_cnt = edmmt_pkg::TRAIL_LAST;
      default: first_cnt = 4'h0;
    endcase
  endfunction

  // ****************************************************************
  // Field decode and address mapping.
  // ****************************************************************
  // Timing fields are read live, so software must change them only while
  // no off-chip move runs; a change mid-move stretches or cuts a phase.
  // programmable timing fields.
  // latch width code is length minus one.
  assign mode = r.cfg[edmmt_pkg::CFG_MODE_LSB +: 2];
  assign t_ale = r.cfg[1:0];
  assign t_setup = r.tim[edmmt_pkg::TIM_SETUP_LSB +: 2];
  assign t_strobe = r.tim[edmmt_pkg::TIM_STROBE_LSB +: 4];
  assign t_hold = r.tim[edmmt_pkg::TIM_HOLD_LSB +: 2];

  // page high byte, pointer low byte.
  // data pointer is the whole address.
  assign ea = form16_i ? data_pointer_i : {3'h0, r.page, ptr_i};

  // low bits index the RAM, so high addresses wrap.
  assign ram_idx = ea[edmmt_pkg::IDX_W-1:0];

  // Destination choice per mapping mode.
  always_comb begin
    case (mode)
      edmmt_pkg::MODE_INT: go_off = 1'b0;
      edmmt_pkg::MODE_EXT: go_off = 1'b1;
      default: begin
        // 8-bit form follows page MSB.
        // The whole pointer is compared, so addresses far above the RAM
        // still go off-chip instead of wrapping back into it.
        if (form16_i) go_off = (ea >= edmmt_pkg::RAM_BOUND);
        else go_off = r.page[edmmt_pkg::PAGE_MSB];
      end
    endcase
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // One process holds the register file and the move sequencer.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    ram_we = 1'b0;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        edmmt_pkg::ADDR_PAGE: next_r.sfr_q = {3'h0, r.page};
        edmmt_pkg::ADDR_CFG: next_r.sfr_q = {4'h0, r.cfg};
        edmmt_pkg::ADDR_TIM: next_r.sfr_q = r.tim;
        default: next_r.sfr_q = 8'h00;
      endcase
    end
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        // only the five-bit page is stored.
        edmmt_pkg::ADDR_PAGE: next_r.page = sfr_wdata_i[4:0];
        edmmt_pkg::ADDR_CFG: next_r.cfg = sfr_wdata_i[3:0];
        edmmt_pkg::ADDR_TIM: next_r.tim = sfr_wdata_i;
        default: next_r.page = r.page;
      endcase
    end
    // Requests that arrive while a move runs are dropped; the core is
    // expected to wait for done before it issues the next one.
    case (r.ph)
      edmmt_pkg::PH_IDLE: begin
        if (req_i && !go_off) begin
          ram_we = wr_i;
          next_r.rdat = wr_i ? r.rdat : ram[ram_idx];
          next_r.done = 1'b1;
        end else if (req_i) begin
          next_r.ph = edmmt_pkg::PH_LEAD;
          next_r.cnt = edmmt_pkg::LEAD_LAST;
          next_r.is_wr = wr_i;
          // Operands are captured on the taking edge, so the core may
          // change them while the off-chip phases run.
          next_r.wdat = wdata_i;
          next_r.lo = form16_i ? data_pointer_i[7:0] : ptr_i;
          next_r.hi = form16_i ? data_pointer_i[11:8] : r.page[3:0];
          next_r.hi_en = form16_i || (mode == edmmt_pkg::MODE_BANK);
        end
      end
      default: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          // four fixed cycles around programmed ones.
          next_r.ph = follow(r.ph, mux_mode_i, t_setup, t_hold);
          next_r.cnt = first_cnt(next_r.ph, t_setup, t_strobe,
                                 t_hold, t_ale);
          // The data pins are sampled with no synchroniser: the programmed
          // strobe width is what guarantees that they have settled.
          if (r.ph == edmmt_pkg::PH_STROBE && !r.is_wr) begin
            next_r.rdat = ad_i;
          end
          if (r.ph == edmmt_pkg::PH_TRAIL) begin
            next_r.done = 1'b1;
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // Clock enable freezes the sequencer and registers alike.
  // Reset does not wait for the clock enable, so a frozen unit can still
  // be brought back to its known state.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r.ph <= edmmt_pkg::PH_IDLE;
      r.cnt <= 4'h0;
      r.page <= edmmt_pkg::RST_PAGE;
      r.cfg <= edmmt_pkg::RST_CFG;
      r.tim <= edmmt_pkg::RST_TIM;
      r.is_wr <= 1'b0;
      r.lo <= 8'h00;
      r.hi <= 4'h0;
      r.hi_en <= 1'b0;
      r.wdat <= 8'h00;
      r.rdat <= 8'h00;
      r.done <= 1'b0;
      r.sfr_q <= 8'h00;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // The RAM has no reset; it is written only by on-chip moves.
  always_ff @(posedge core_clk_i) begin
    if (ce_i && ram_we) begin
      ram[ram_idx] <= wdata_i;
    end
  end

  // ****************************************************************
  // Pin drive.
  // ****************************************************************
  logic in_move;
  logic data_ph;
  assign in_move = (r.ph != edmmt_pkg::PH_IDLE);
  assign data_ph = (r.ph == edmmt_pkg::PH_SETUP) ||
                   (r.ph == edmmt_pkg::PH_STROBE) ||
                   (r.ph == edmmt_pkg::PH_HOLD);

  // pins are owned only while a move runs.
  assign bus_own_o = in_move;
  assign busy_o = in_move;
  // Upper lines stay with the port latches unless the data pointer form or bank mode drives them,
  // which lets software bank external memory through the port itself.
  assign addr_hi_o = r.hi;
  assign addr_hi_oe_o = in_move && r.hi_en;
  assign addr_lo_o = r.lo;
  assign addr_lo_oe_o = in_move && !mux_mode_i;
  // address while latch enable high, data later.
  // the latch keeps the byte after the fall.
  assign ale_o = (r.ph == edmmt_pkg::PH_ALEH);
  assign ad_o = (mux_mode_i && !data_ph) ? r.lo : r.wdat;
  assign ad_oe_o = mux_mode_i ?
                   ((r.ph == edmmt_pkg::PH_ALEH) ||
                    (r.ph == edmmt_pkg::PH_ALEL) ||
                    (data_ph && r.is_wr)) :
                   (data_ph && r.is_wr);
  assign rd_n_o = !((r.ph == edmmt_pkg::PH_STROBE) && !r.is_wr);
  assign wr_n_o = !((r.ph == edmmt_pkg::PH_STROBE) && r.is_wr);
  assign rdata_o = r.rdat;
  assign done_o = r.done;
  assign sfr_rdata_o = r.sfr_q;

endmodule

//--- edmmt_monitor.sv
// Assertion checker for the external data move unit pins.
module edmmt_monitor (
  input wire logic core_clk_i, // Clock.
  input wire logic resetn_i, // Reset, active low.
  input wire logic mux_mode_i, // Shared bus style.
  input wire logic done_o, // Move done.
  input wire logic busy_o, // Off-chip move.
  input wire logic bus_own_o, // Pin ownership.
  input wire logic addr_hi_oe_o, // Upper line enable.
  input wire logic addr_lo_oe_o, // Lower line enable.
  input wire logic ad_oe_o, // Data pin enable.
  input wire logic ale_o, // Latch enable.
  input wire logic rd_n_o, // Read strobe.
  input wire logic wr_n_o // Write strobe.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Pin side checks.
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Parked pins must stay with the port latches.
  AST_IDLE_PINS: assert property (!busy_o |-> !ad_oe_o &&
    !addr_lo_oe_o && !addr_hi_oe_o && rd_n_o && wr_n_o && !ale_o)
    else $error("pins driven while idle");
  AST_OWN: assert property (bus_own_o == busy_o)
    else $error("ownership differs from busy");
  AST_ONE_STROBE: assert property (rd_n_o || wr_n_o)
    else $error("both strobes low");
  AST_PLAIN_MIN: assert property ($rose(busy_o) && !mux_mode_i |->
    busy_o[*5]) else $error("plain move too short");
  AST_MUX_MIN: assert property ($rose(busy_o) && mux_mode_i |->
    busy_o[*7]) else $error("shared bus move too short");
  AST_DONE_END: assert property ($fell(busy_o) && $past(resetn_i)
    |-> done_o) else $error("no done at end of move");
  AST_ALE_ADDR: assert property (ale_o |-> mux_mode_i && ad_oe_o)
    else $error("latch enable without address");
  AST_RD_FLOAT: assert property (!rd_n_o |-> !ad_oe_o)
    else $error("data driven during read");
  AST_WR_DRIVE: assert property (!wr_n_o |-> ad_oe_o)
    else $error("data not driven during write");
  AST_LO_PLAIN: assert property (!rd_n_o && !mux_mode_i |->
    addr_lo_oe_o) else $error("low lines not driven");
  COV_RD: cover property ($fell(rd_n_o));
  COV_WR: cover property ($fell(wr_n_o));
  COV_ALE: cover property ($rose(ale_o));
endmodule

bind edmmt_ctrl edmmt_monitor u_mon (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .mux_mode_i(mux_mode_i), .done_o(done_o),
  .busy_o(busy_o), .bus_own_o(bus_own_o), .addr_hi_oe_o(addr_hi_oe_o),
  .addr_lo_oe_o(addr_lo_oe_o), .ad_oe_o(ad_oe_o), .ale_o(ale_o),
  .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));

//--- edmmt_sram_model.sv
// Off-chip memory with an address latch, as seen on the pins.
module edmmt_sram_model (
  input wire logic clk_i, // Clock.
  input wire logic mux_i, // Shared bus style.
  input wire logic [3:0] hi_i, // Upper address.
  input wire logic hi_oe_i, // Upper enable.
  input wire logic [7:0] lo_i, // Plain low address.
  input wire logic [7:0] ad_i, // Data from the unit.
  input wire logic ad_oe_i, // Data enable.
  input wire logic ale_i, // Latch enable.
  input wire logic rd_n_i, // Read strobe.
  input wire logic wr_n_i, // Write strobe.
  output logic [7:0] bus_o // Resolved data pins.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];
  logic [7:0] lat;
  logic [7:0] last;
  logic [11:0] a;
  // ****************************************
  // Latch and memory.
  // ****************************************
  // latch follows bus
  always_latch if (ale_i) lat = bus_o;
  // Undriven upper lines sit parked high by the port latches.
  assign a = {hi_oe_i ? hi_i : 4'hF, mux_i ? lat : lo_i};
  // A floating bus shows a changing pattern, never the old value.
  always_comb bus_o = ad_oe_i ? ad_i : (!rd_n_i ? mem[a] : ~last);
  // Writes land while the strobe is low.
  always_ff @(posedge clk_i) begin
    last <= bus_o;
    if (!wr_n_i) mem[a] <= bus_o;
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the external data move unit.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, mux = 1'b0, req = 1'b0, wr = 1'b0;
  logic f16 = 1'b0, swr = 1'b0, srd = 1'b0, ce = 1'b1;
  logic [7:0] sa = 8'h00, sd = 8'h00, ptr = 8'h00, wdat = 8'h00, d;
  logic [15:0] data_pointer = 16'h0000;
  logic [7:0] srdat, rdat, ado, adi, alo;
  logic [3:0] ahi;
  logic done, busy, hoe, loe, adoe, ale, rdn, wrn, s_hoe;
  logic [11:0] s_a;
  logic [7:0] s_ad;
  int miscompares = 0, checked = 0, na;
  // ****************************************
  // Clock, unit and far side.
  // ****************************************
  // Half period of the 50 MHz clock.
  always #10 clk = ~clk;
  edmmt_ctrl u_dut (.core_clk_i(clk), .resetn_i(rstn), .ce_i(ce),
    .sfr_addr_i(sa), .sfr_wr_i(swr), .sfr_rd_i(srd), .sfr_wdata_i(sd),
    .sfr_rdata_o(srdat), .mux_mode_i(mux), .req_i(req), .wr_i(wr),
    .form16_i(f16), .data_pointer_i(data_pointer), .ptr_i(ptr), .wdata_i(wdat),
    .rdata_o(rdat), .done_o(done), .busy_o(busy), .bus_own_o(),
    .addr_hi_o(ahi), .addr_hi_oe_o(hoe), .addr_lo_o(alo),
    .addr_lo_oe_o(loe), .ad_o(ado), .ad_oe_o(adoe), .ad_i(adi),
    .ale_o(ale), .rd_n_o(rdn), .wr_n_o(wrn));
  edmmt_sram_model u_mem (.clk_i(clk), .mux_i(mux), .hi_i(ahi),
    .hi_oe_i(hoe), .lo_i(alo), .ad_i(ado), .ad_oe_i(adoe), .ale_i(ale),
    .rd_n_i(rdn), .wr_n_i(wrn), .bus_o(adi));
  task automatic results();
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wrr(input logic [7:0] a, v);
    @(posedge clk);
    sa <= a;
    sd <= v;
    swr <= 1'b1;
    @(posedge clk);
    swr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    @(posedge clk);
    sa <= a;
    srd <= 1'b1;
    @(posedge clk);
    srd <= 1'b0;
    @(negedge clk);
    chk(srdat === e, "register read");
  endtask
  // One move; the count is negedges from the taking edge to done.
  task automatic mv(input logic w, f, input logic [15:0] dp,
    input logic [7:0] p, wd, input int en);
    int n;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    f16 <= f;
    data_pointer <= dp;
    ptr <= p;
    wdat <= wd;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    na = 0;
    s_hoe = 1'bx;
    do begin
      @(negedge clk);
      n++;
      if (!rdn || !wrn) begin
        s_hoe = hoe;
        s_a = {ahi, alo};
      end
      if (ale === 1'b1) begin
        na++;
        s_ad = ado;
      end
    end while (done !== 1'b1 && n < 60);
    if (n >= 60) begin
      miscompares++;
      results();
    end else begin
      d = rdat;
      chk(n == en, "move length");
    end
  endtask
  task automatic t_regs();
    rdc(8'hAA, 8'h00);
    rdc(8'hAB, 8'h03);
    rdc(8'hAF, 8'hFF);
    rdc(8'hAC, 8'h00);
    wrr(8'hAA, 8'hFF);
    rdc(8'hAA, 8'h1F);
  endtask
  task automatic t_int();
    mv(1'b1, 1'b1, 16'h1005, 8'h00, 8'h5A, 1);
    mv(1'b0, 1'b1, 16'h0005, 8'h00, 8'h00, 1);
    chk(d === 8'h5A, "wrap");
    wrr(8'hAA, 8'h11);
    mv(1'b1, 1'b0, 16'h0000, 8'h22, 8'hC3, 1);
    mv(1'b0, 1'b1, 16'h0122, 8'h00, 8'h00, 1);
    chk(d === 8'hC3, "page form");
  endtask
  task automatic t_split();
    wrr(8'hAB, 8'h07);
    mv(1'b1, 1'b1, 16'h0FFF, 8'h00, 8'h11, 1);
    mv(1'b1, 1'b1, 16'h1234, 8'h00, 8'hAB, 27);
    wrr(8'hAF, 8'h00);
    mv(1'b1, 1'b1, 16'h1000, 8'h00, 8'h5C, 6);
    mv(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00, 6);
    chk(d === 8'hAB && s_hoe === 1'b1 && s_a === 12'h234, "dp");
    wrr(8'hAA, 8'h12);
    mv(1'b1, 1'b0, 16'h0000, 8'h34, 8'h77, 6);
    chk(s_hoe === 1'b0 && s_a[7:0] === 8'h34, "no bank");
    wrr(8'hAA, 8'h02);
    mv(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00, 1);
    wrr(8'hAB, 8'h0B);
    wrr(8'hAA, 8'h13);
    mv(1'b1, 1'b0, 16'h0000, 8'h56, 8'h99, 6);
    chk(s_hoe === 1'b1 && s_a === 12'h356, "bank");
    wrr(8'hAB, 8'h0F);
    mv(1'b0, 1'b1, 16'h0234, 8'h00, 8'h00, 6);
    chk(d === 8'hAB && s_hoe === 1'b1 && s_a === 12'h234, "ext");
    mv(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00, 6);
    chk(d === 8'h77 && s_hoe === 1'b0, "ext page");
  endtask
  task automatic t_mux();
    wrr(8'hAF, 8'h49);
    wrr(8'hAB, 8'h0D);
    mux <= 1'b1;
    mv(1'b1, 1'b1, 16'h0456, 8'h00, 8'h3C, 14);
    chk(na == 2 && s_ad === 8'h56, "latch phase");
    wrr(8'hAB, 8'h0C);
    mv(1'b0, 1'b1, 16'h0456, 8'h00, 8'h00, 12);
    chk(na == 1 && d === 8'h3C, "short latch");
  endtask
  // Clock enable low for three edges stretches the move by three.
  task automatic t_ce();
    fork
      mv(1'b0, 1'b1, 16'h0456, 8'h00, 8'h00, 15);
      begin
        repeat (4) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk(d === 8'h3C, "frozen move");
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_int();
    t_split();
    t_mux();
    t_ce();
    results();
  end
endmodule
